// *** shared/hco_pkg.sv ***
// hco_pkg: constants, types and state enums for the hardware cursor overlay
// assumes: one 50 MHz pixel-pipeline clock, 32-bit wishbone, 21-bit memory
package hco_pkg;
  // register byte offsets
  localparam logic [7:0] HCO_OFS_EXT   = 8'h00;
  localparam logic [7:0] HCO_OFS_CTRL  = 8'h20;
  localparam logic [7:0] HCO_OFS_COLOR = 8'h24;
  localparam logic [7:0] HCO_OFS_POS   = 8'h2c;
  localparam logic [7:0] HCO_OFS_BASE  = 8'h30;
  // field positions
  localparam int HCO_EXT_CUR_BIT   = 1;
  localparam int HCO_CTRL_EN_BIT   = 0;
  localparam int HCO_CTRL_BIG_BIT  = 1;
  localparam int HCO_CTRL_REFB_BIT = 2;
  localparam int HCO_STAT_ROW_BIT  = 8;
  localparam int HCO_STAT_BUSY_BIT = 9;
  localparam int HCO_COL1_LSB      = 16;
  localparam int HCO_POS_Y_LSB     = 16;
  localparam int HCO_COORD_W       = 12;
  localparam int HCO_BASE_W        = 11;
  localparam int HCO_SLOT_SH       = 10;
  localparam int HCO_ADDR_W        = 21;
  // reset values
  localparam logic [15:0] HCO_COLOR_RST = 16'h0000;
  localparam logic [11:0] HCO_POS_RST   = 12'h000;
  localparam logic [10:0] HCO_BASE_RST  = 11'h000;
  // coordinate limits: -2048 is outside the legal range
  localparam logic [11:0] HCO_COORD_BAD = 12'h800;
  localparam logic [11:0] HCO_COORD_MIN = 12'h801;
  // fetch sequencing
  localparam logic [1:0] HCO_LAST_WORD_SMALL = 2'h1;
  localparam logic [1:0] HCO_LAST_WORD_BIG   = 2'h3;

  typedef enum logic {HCO_IDLE, HCO_FETCH} hco_fsm_e;

  // one pixel of the incoming display stream
  typedef struct packed {
    logic        de;
    logic        vid_sel;
    logic [15:0] gfx;
    logic [15:0] vid;
    logic [11:0] x;
  } hco_pix_s;
endpackage : hco_pkg

// *** core/hco_line_buf.sv ***
// hco_line_buf: one cursor line of interleaved mask/image pattern words
// assumes: written during blanking, read by column during active display
`timescale 1ns/10ps
module hco_line_buf
  import hco_pkg::*;
#(
  parameter int WORDS = 4
) (
  // clock
  input  wire logic        clk_i,
  // write side
  input  wire logic        we_i,
  input  wire logic [1:0]  widx_i,
  input  wire logic [31:0] wdata_i,
  // read side
  input  wire logic [5:0]  col_i,
  output logic             mask_o,
  output logic             img_o
);
  logic [31:0] mem [WORDS];
  logic [31:0] word;
  logic [2:0]  k;

  // storage needs no reset: a line is refetched before it is shown
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[widx_i] <= wdata_i;
    end
  end

  // msb of each byte is the leftmost pixel, low byte pair first
  assign word   = mem[col_i[5:4]];
  assign k      = col_i[2:0];
  assign mask_o = word[{col_i[3], 1'b0, ~k}];
  assign img_o  = word[{col_i[3], 1'b1, ~k}];
endmodule : hco_line_buf

// *** core/hco_pix_mix.sv ***
// hco_pix_mix: decodes one mask/image bit pair over the underlying pixel
// assumes: purely combinational, caller registers the result
`timescale 1ns/10ps
module hco_pix_mix
  import hco_pkg::*;
(
  // pattern bits
  input  wire logic        mask_i,
  input  wire logic        img_i,
  // colours and background
  input  wire logic [15:0] col0_i,
  input  wire logic [15:0] col1_i,
  input  wire logic [15:0] under_i,
  // result
  output logic [15:0]      pix_o
);
  // colours bypass any palette lookup
  always_comb begin
    case ({mask_i, img_i})
      2'b00:   pix_o = col0_i;
      2'b01:   pix_o = col1_i;
      2'b10:   pix_o = under_i;
      2'b11:   pix_o = ~under_i;
      default: pix_o = under_i;
    endcase
  end
endmodule : hco_pix_mix

// *** core/hco_cursor.sv ***
// hco_cursor: hardware cursor overlay with wishbone registers
// assumes: line_start_i pulses in blanking before each line, with that
// line's y; memory answers mem_req_o before the first active pixel
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps

module hco_cursor
  import hco_pkg::*;
#(
  parameter logic [11:0] BLANK_X = 12'h010,
  parameter logic [11:0] BLANK_Y = 12'h008
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // display memory read port
  output logic             mem_req_o,
  output logic [20:0]      mem_addr_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_dat_i,
  // line timing
  input  wire logic        line_start_i,
  input  wire logic [11:0] line_y_i,
  // pixel stream
  input  wire hco_pix_s    pix_i,
  output logic [15:0]      pix_o,
  output logic             pix_de_o
);
  typedef struct packed {
    logic        ext_en;
    logic        en;
    logic        big;
    logic        ref_blk;
    logic [15:0] col0;
    logic [15:0] col1;
    logic [11:0] px;
    logic [11:0] py;
    logic [10:0] base;
    logic        ack;
    logic [31:0] rdat;
    hco_fsm_e    fsm;
    logic [1:0]  widx;
    logic [5:0]  row;
    logic        row_ok;
    logic [15:0] pix;
    logic        pix_de;
  } hco_state_s;

  hco_state_s q;
  hco_state_s d;

  logic               req;
  logic               cur_sel;
  logic [31:0]        rd_mux;
  logic [31:0]        pos_w;
  logic [31:0]        base_w;
  logic signed [12:0] cx;
  logic signed [12:0] cy;
  logic signed [12:0] dx;
  logic signed [12:0] dy;
  logic               in_x;
  logic               in_y;
  logic               hit;
  logic               pmask;
  logic               pimg;
  logic [15:0]        under;
  logic [15:0]        mixed;
  logic [1:0]         last_w;
  logic [9:0]         slot_ofs;

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // bus decode; cursor registers hide while extension enable is clear
  assign req     = wb_cyc_i && wb_stb_i && !q.ack;
  assign cur_sel = q.ext_en;

  // read-back image of the register file
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      HCO_OFS_EXT: rd_mux[HCO_EXT_CUR_BIT] = q.ext_en;
      HCO_OFS_CTRL: begin
        if (cur_sel) begin
          rd_mux[HCO_CTRL_EN_BIT]   = q.en;
          rd_mux[HCO_CTRL_BIG_BIT]  = q.big;
          rd_mux[HCO_CTRL_REFB_BIT] = q.ref_blk;
          rd_mux[HCO_STAT_ROW_BIT]  = q.row_ok;
          rd_mux[HCO_STAT_BUSY_BIT] = (q.fsm == HCO_FETCH);
        end
      end
      HCO_OFS_COLOR: begin
        if (cur_sel) begin
          rd_mux = {q.col1, q.col0};
        end
      end
      HCO_OFS_POS: begin
        if (cur_sel) begin
          rd_mux = {4'h0, q.py, 4'h0, q.px};
        end
      end
      HCO_OFS_BASE: begin
        if (cur_sel) begin
          rd_mux[HCO_BASE_W-1:0] = q.base;
        end
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // position write image, built from the current value and byte lanes
  assign pos_w = merge({4'h0, q.py, 4'h0, q.px}, wb_dat_i, wb_sel_i);
  // base write image; a function result cannot be sliced in place
  assign base_w = merge({21'h0, q.base}, wb_dat_i, wb_sel_i);

  // coordinate reference: blank start sits BLANK_X/Y before display enable
  assign cx = $signed({q.px[11], q.px})
            - (q.ref_blk ? $signed({1'b0, BLANK_X}) : 13'sd0);
  assign cy = $signed({q.py[11], q.py})
            - (q.ref_blk ? $signed({1'b0, BLANK_Y}) : 13'sd0);
  assign dy = $signed({1'b0, line_y_i}) - cy;
  assign dx = $signed({1'b0, pix_i.x}) - cx;
  // window test by size; a clear sign bit means on or right of the start
  assign in_y = q.big ? (dy[12:6] == 7'h00)
                      : (dy[12:5] == 8'h00);
  assign in_x = q.big ? (dx[12:6] == 7'h00)
                      : (dx[12:5] == 8'h00);
  // a line still being fetched shows no cursor rather than stale data
  assign hit  = pix_i.de && q.row_ok && in_x
              && (q.fsm == HCO_IDLE);

  // fetch address: slot base, then line stride, then word
  assign last_w   = q.big ? HCO_LAST_WORD_BIG : HCO_LAST_WORD_SMALL;
  assign slot_ofs = q.big ? {q.row, q.widx, 2'b00}
                          : {2'b00, q.row[4:0], q.widx[0], 2'b00};
  assign mem_req_o  = (q.fsm == HCO_FETCH);
  assign mem_addr_o = {q.base, slot_ofs};

  hco_line_buf #(
    .WORDS   (4)
  ) u_line_buf (
    .clk_i   (clk_i),
    .we_i    (mem_req_o && mem_ack_i),
    .widx_i  (q.widx),
    .wdata_i (mem_dat_i),
    .col_i   (dx[5:0]),
    .mask_o  (pmask),
    .img_o   (pimg)
  );

  // underlying pixel is live video or graphics, whichever is shown
  assign under = pix_i.vid_sel ? pix_i.vid : pix_i.gfx;

  hco_pix_mix u_pix_mix (
    .mask_i  (pmask),
    .img_i   (pimg),
    .col0_i  (q.col0),
    .col1_i  (q.col1),
    .under_i (under),
    .pix_o   (mixed)
  );

  // next-state logic for bus, fetch sequencer and pixel output
  always_comb begin
    d     = q;
    d.ack = req;
    if (req) begin
      d.rdat = wb_we_i ? 32'h0000_0000 : rd_mux;
    end
    if (req && wb_we_i) begin
      case (wb_adr_i)
        HCO_OFS_EXT: begin
          if (wb_sel_i[0]) begin
            d.ext_en = wb_dat_i[HCO_EXT_CUR_BIT];
          end
        end
        HCO_OFS_CTRL: begin
          if (cur_sel && wb_sel_i[0]) begin
            d.en      = wb_dat_i[HCO_CTRL_EN_BIT];
            d.big     = wb_dat_i[HCO_CTRL_BIG_BIT];
            d.ref_blk = wb_dat_i[HCO_CTRL_REFB_BIT];
          end
        end
        HCO_OFS_COLOR: begin
          if (cur_sel) begin
            {d.col1, d.col0} = merge({q.col1, q.col0},
                                     wb_dat_i, wb_sel_i);
          end
        end
        HCO_OFS_POS: begin
          if (cur_sel) begin
            d.px = pos_w[HCO_COORD_W-1:0];
            d.py = pos_w[HCO_POS_Y_LSB +: HCO_COORD_W];
            // -2048 saturates to the legal limit
            if (d.px == HCO_COORD_BAD) begin
              d.px = HCO_COORD_MIN;
            end
            if (d.py == HCO_COORD_BAD) begin
              d.py = HCO_COORD_MIN;
            end
          end
        end
        HCO_OFS_BASE: begin
          if (cur_sel) begin
            d.base = base_w[HCO_BASE_W-1:0];
          end
        end
        default: ;
      endcase
    end
    // a line start restarts the fetch only when enabled and the line is in the window, abandoning a late one
    case (q.fsm)
      HCO_IDLE: begin
        if (mem_ack_i) begin
          d.fsm = HCO_IDLE;
        end
      end
      HCO_FETCH: begin
        if (mem_ack_i) begin
          d.widx = q.widx + 2'h1;
          if (q.widx == last_w) begin
            d.fsm = HCO_IDLE;
          end
        end
      end
      default: d.fsm = HCO_IDLE;
    endcase
    if (line_start_i) begin
      d.row_ok = q.en && in_y;
      d.row    = dy[5:0];
      d.widx   = 2'h0;
      d.fsm    = (q.en && in_y) ? HCO_FETCH : HCO_IDLE;
    end
    d.pix    = hit ? mixed : under;
    d.pix_de = pix_i.de;
  end

  // single state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q        <= '0;
      q.col0   <= HCO_COLOR_RST;
      q.col1   <= HCO_COLOR_RST;
      q.px     <= HCO_POS_RST;
      q.py     <= HCO_POS_RST;
      q.base   <= HCO_BASE_RST;
      q.fsm    <= HCO_IDLE;
    end else begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign pix_o    = q.pix;
  assign pix_de_o = q.pix_de;

  // ack lasts exactly one cycle, one edge after the request
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acked");
  // locked colour register reads zero; locked cursor registers ignore writes
  a_lock_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && !q.ext_en && wb_adr_i == HCO_OFS_COLOR)
    |=> wb_dat_o == 32'h0000_0000) else $error("locked read leaked");
  a_lock_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_we_i && !q.ext_en) |=> $stable({q.col0, q.col1, q.base,
    q.px, q.py, q.en, q.big})) else $error("locked write took");
  a_pos_in_range: assert property (@(posedge clk_i) disable iff (rst_i)
    q.px != HCO_COORD_BAD && q.py != HCO_COORD_BAD)
    else $error("coordinate out of range");
  a_fetch_in_slot: assert property (@(posedge clk_i) disable iff (rst_i)
    (mem_req_o && !q.big) |-> (mem_addr_o[9:8] == 2'b00
    && mem_addr_o[7:3] == q.row[4:0])) else $error("small fetch stray");
  a_fetch_words: assert property (@(posedge clk_i) disable iff (rst_i)
    (mem_req_o && mem_ack_i && q.widx == last_w && !line_start_i)
    |=> !mem_req_o) else $error("fetch word count wrong");
  a_mix_colour0: assert property (@(posedge clk_i) disable iff (rst_i)
    (hit && !pmask && !pimg) |=> pix_o == $past(q.col0))
    else $error("colour 0 not shown");
  a_pass_offscreen: assert property (@(posedge clk_i) disable iff (rst_i)
    !hit |=> pix_o == $past(under))
    else $error("cursor outside its window");
endmodule : hco_cursor

// *** test/hco_mem_model.sv ***
// hco_mem_model: display memory behind the cursor pattern fetch port
// assumes: word-aligned byte addresses, each request held until its ack
`timescale 1ns/10ps
module hco_mem_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // request side
  input  wire logic        mem_req_i,
  input  wire logic [20:0] mem_addr_i,
  input  wire logic        slow_i,
  // answer side
  output logic             mem_ack_o,
  output logic [31:0]      mem_dat_o
);
  logic [1:0] wait_cnt;

  // mask in bytes 0/2, image in bytes 1/3; upper bytes follow the address
  // so that a wrong slot or line offset shows up as wrong pixels
  function automatic logic [31:0] word_at(input logic [20:0] a);
    return {a[9:2] ^ 8'h5a, a[17:10], 8'h33, 8'h0f};
  endfunction : word_at

  // answer promptly or after two idle cycles; data lines toggle when idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_ack_o <= 1'b0;
      mem_dat_o <= 32'h0;
      wait_cnt  <= 2'h0;
    end else if (mem_req_i && !mem_ack_o &&
                 wait_cnt == (slow_i ? 2'h2 : 2'h0)) begin
      mem_ack_o <= 1'b1;
      mem_dat_o <= word_at(mem_addr_i);
      wait_cnt  <= 2'h0;
    end else begin
      mem_ack_o <= 1'b0;
      mem_dat_o <= ~mem_dat_o; // stale words never look fresh
      if (mem_req_i && !mem_ack_o) begin
        wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule : hco_mem_model

// *** test/tb.sv ***
// tb: register, fetch and pixel-merge tests of the cursor overlay
// assumes: hco_mem_model answers the fetch port, wishbone classic cycles
`timescale 1ns/10ps
module tb;
  import hco_pkg::*;
  localparam logic [11:0] BX = 12'h010;
  localparam logic [11:0] BY = 12'h008;
  localparam logic [15:0] C0 = 16'h1234;
  localparam logic [15:0] C1 = 16'hfedc;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, mem_dat_i, q;
  logic        mem_req_o, mem_ack_i, line_start_i, pix_de_o, slow;
  logic [20:0] mem_addr_o, line_addr;
  logic [11:0] line_y_i;
  logic [15:0] pix_o;
  hco_pix_s    pix_i;
  int          miscompares, num_checks, words;

  hco_cursor #(.BLANK_X(BX), .BLANK_Y(BY)) i_hco_cursor (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
    .mem_dat_i(mem_dat_i), .line_start_i(line_start_i),
    .line_y_i(line_y_i), .pix_i(pix_i), .pix_o(pix_o), .pix_de_o(pix_de_o));
  hco_mem_model i_hco_mem_model (
    .clk_i(clk_i), .rst_i(rst_i), .mem_req_i(mem_req_o),
    .mem_addr_i(mem_addr_o), .slow_i(slow), .mem_ack_o(mem_ack_i),
    .mem_dat_o(mem_dat_i));

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // one classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // no timeout here: ack ends this wait, or the watchdog if ack never comes
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  // each fetched word must come from the slot, line and word expected
  always @(posedge clk_i) begin
    if (mem_ack_i === 1'b1) begin
      check("mem_addr", 32'(mem_addr_o), 32'(line_addr + 21'(words * 4)));
      words = words + 1;
    end
  end

  // program one cursor, fetch one line, then sweep 72 pixels across it
  task automatic run_line(input logic [2:0] ctrl, input logic [10:0] base,
                          input logic [11:0] px, input logic [11:0] py,
                          input logic [11:0] ly, input logic slw);
    int sx, sy, row, sz, nw, x, c, k;
    logic [31:0] d;
    logic [15:0] u, e;
    wb(1'b1, HCO_OFS_POS, {4'h0, py, 4'h0, px});
    wb(1'b1, HCO_OFS_BASE, {21'h0, base});
    wb(1'b1, HCO_OFS_CTRL, {29'h0, ctrl});
    slow <= slw;
    sx = int'($signed(px)) - (ctrl[2] ? int'(BX) : 0);
    sy = int'($signed(py)) - (ctrl[2] ? int'(BY) : 0);
    row = int'(ly) - sy;
    sz = ctrl[1] ? 64 : 32;
    nw = (ctrl[0] && row >= 0 && row < sz) ? sz / 16 : 0;
    line_addr = {base, 10'h0} + 21'(row * sz / 4);
    words = 0;
    @(posedge clk_i);
    line_start_i <= 1'b1;
    line_y_i     <= ly;
    @(posedge clk_i);
    line_start_i <= 1'b0;
    do begin
      @(posedge clk_i);
    end while (mem_req_o !== 1'b0);
    check("words", 32'(words), 32'(nw));
    for (x = 0; x < 72; x++) begin
      u = x[0] ? 16'h5500 | 16'(x) : 16'hab00 | 16'(x);
      @(posedge clk_i);
      pix_i <= '{de:1'b1, vid_sel:x[0], gfx:16'hab00 | 16'(x),
                 vid:16'h5500 | 16'(x), x:12'(x)};
      @(negedge clk_i);
      @(negedge clk_i);
      c = x - sx;
      e = u;
      if (nw != 0 && c >= 0 && c < sz) begin
        d = i_hco_mem_model.word_at(line_addr + 21'((c / 16) * 4));
        k = c % 16;
        if (d[(k / 8) * 16 + 7 - k % 8]) e = d[(k / 8) * 16 + 15 - k % 8] ? ~u : u;
        else e = d[(k / 8) * 16 + 15 - k % 8] ? C1 : C0;
      end
      check("pix", 32'(pix_o), 32'(e));
      check("pix_de", 32'(pix_de_o), 32'h1);
    end
    @(posedge clk_i);
    pix_i <= '0;
  endtask : run_line

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // cut a hang short well after the expected 1300 or so cycles
  initial begin
    #400000;
    miscompares++;
    complete_run();
  end

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, line_start_i, slow} = 5'h0;
    {wb_adr_i, wb_dat_i, line_y_i} = '0;
    wb_sel_i = 4'hf;
    pix_i = '0;
    line_addr = '0;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, HCO_OFS_EXT, 32'h0);
    check("ext_rst", q, 32'h0);
    wb(1'b1, HCO_OFS_COLOR, 32'hffff_ffff);
    wb(1'b1, HCO_OFS_EXT, 32'h2);
    wb(1'b0, HCO_OFS_EXT, 32'h0);
    check("ext", q, 32'h2);
    wb(1'b0, HCO_OFS_COLOR, 32'h0);
    check("color_dropped", q, 32'h0);
    wb(1'b0, HCO_OFS_BASE, 32'h0);
    check("base_rst", q, 32'h0);
    wb(1'b1, HCO_OFS_COLOR, {C1, C0});
    wb(1'b0, HCO_OFS_COLOR, 32'h0);
    check("color", q, {C1, C0});
    wb(1'b1, HCO_OFS_POS, 32'h0800_07ff);
    wb(1'b0, HCO_OFS_POS, 32'h0);
    check("pos_clip", q, 32'h0801_07ff);
    wb(1'b0, 8'h10, 32'h0);
    check("unmapped", q, 32'h0);
    run_line(3'b001, 11'h003, 12'h000, 12'h000, 12'h000, 1'b0);
    wb(1'b0, HCO_OFS_CTRL, 32'h0);
    check("ctrl", q, 32'h0000_0101);
    run_line(3'b001, 11'h003, 12'h004, 12'hfff, 12'h01e, 1'b1);
    run_line(3'b011, 11'h7ff, 12'hffc, 12'h000, 12'h002, 1'b1);
    run_line(3'b011, 11'h005, 12'h020, 12'h002, 12'h041, 1'b0);
    run_line(3'b011, 11'h005, 12'h020, 12'h002, 12'h042, 1'b0);
    run_line(3'b101, 11'h001, BX + 12'h002, BY, 12'h001, 1'b0);
    run_line(3'b000, 11'h001, 12'h000, 12'h000, 12'h000, 1'b0);
    run_line(3'b001, 11'h002, 12'h7ff, 12'h801, 12'h000, 1'b0);
    wb(1'b1, HCO_OFS_EXT, 32'h0);
    wb(1'b0, HCO_OFS_POS, 32'h0);
    check("pos_hidden", q, 32'h0);
    complete_run();
  end
endmodule : tb
